// *** logic/eem_pkg.sv ***
// shared constants for the encoder emulation block
package eem_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 200;
  localparam int EDGE_SPACING_NS = 200;
  localparam int MONO_SLOW_NS = 13000;
  localparam int MONO_FAST_NS = 3000;
  // least time rounds up, monoflop is a nominal figure
  localparam int EDGE_SPACING_CYC =
    (EDGE_SPACING_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int MONO_SLOW_CYC = MONO_SLOW_NS * CLK_FREQ_MHZ / 1000;
  localparam int MONO_FAST_CYC = MONO_FAST_NS * CLK_FREQ_MHZ / 1000;
  localparam int MONO_W = 12;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_LINES = 12'h004;
  localparam logic [11:0] ADDR_ZOFS = 12'h008;
  localparam logic [11:0] ADDR_INTERP = 12'h00c;
  localparam logic [11:0] ADDR_COUNT = 12'h010;
  localparam logic [11:0] ADDR_FRAME = 12'h014;
  localparam logic [11:0] ADDR_TURNS = 12'h018;

  // control register fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_DIR_INV = 2;
  localparam int CTL_MULTI = 3;
  localparam int CTL_BINARY = 4;
  localparam int CTL_FAST = 5;
  localparam int CTL_CLK_INV = 6;
  localparam int CTL_ENCODER = 7;
  localparam int CTL_COMMUT = 8;
  localparam int CTL_POLE_LSB = 9;
  localparam int CTL_HOMED = 11;
  localparam int CTL_W = 12;
  localparam logic [CTL_W-1:0] CTL_RESET = 12'h000;

  // emulation_function_select values
  typedef enum logic [1:0] {
    EEM_FN_OFF = 2'b00,
    EEM_FN_INCR = 2'b01,
    EEM_FN_SSI = 2'b10,
    EEM_FN_INTERP = 2'b11
  } eem_fn_t;

  // ----------------------------------------------------------------
  // resolution and frame layout
  // ----------------------------------------------------------------
  localparam int LINES_W = 20;
  localparam logic [LINES_W-1:0] LINES_RESET = 20'h00400;
  localparam logic [LINES_W-1:0] LINES_MAX_RES = 20'h01000;
  localparam logic [LINES_W-1:0] LINES_MAX_ENC = 20'h80000;
  localparam logic [2:0] INTERP_MIN = 3'h2;
  localparam logic [2:0] INTERP_MAX = 3'h7;
  localparam int ANGLE_W = 24;
  localparam int FRAME_W = 24;
  localparam int HALF_W = 12;
  localparam logic [HALF_W-1:0] HALF_ZERO = 12'h000;
  localparam logic [HALF_W-1:0] HALF_INVALID = 12'hfff;

endpackage : eem_pkg

// *** logic/eem_sync2.sv ***
// two-stage synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module eem_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // first stage is read by the second stage only
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule : eem_sync2

// *** logic/eem_ssi_shift.sv ***
// serial absolute frame shifter with monoflop end of frame
`timescale 1ns/1ps
module eem_ssi_shift
  import eem_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic link_edge_in,
  input wire logic [FRAME_W-1:0] word_in,
  input wire logic [MONO_W-1:0] mono_cyc_in,
  output logic data_out,
  output logic busy_out,
  output logic [FRAME_W-1:0] latched_out
);
  typedef enum logic [0:0] {
    EEM_SSI_IDLE = 1'b0,
    EEM_SSI_ACTIVE = 1'b1
  } eem_ssi_st_t;

  localparam logic [4:0] BITS = 5'(FRAME_W);

  eem_ssi_st_t st_reg, st_next;
  logic [FRAME_W-1:0] sh_reg, sh_next;
  logic [FRAME_W-1:0] lat_reg, lat_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [MONO_W-1:0] mono_reg, mono_next;
  logic data_reg, data_next;

  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    lat_next = lat_reg;
    cnt_next = cnt_reg;
    mono_next = mono_reg;
    data_next = data_reg;
    case (st_reg)
      EEM_SSI_IDLE: begin
        data_next = 1'b1;
        if (link_edge_in) begin
          // first edge freezes the position word
          sh_next = word_in; // RULE16
          lat_next = word_in;
          cnt_next = BITS; // RULE8
          mono_next = mono_cyc_in;
          st_next = EEM_SSI_ACTIVE;
        end
      end
      EEM_SSI_ACTIVE: begin
        if (link_edge_in) begin
          mono_next = mono_cyc_in;
          if (cnt_reg != 5'h00) begin
            data_next = sh_reg[FRAME_W-1]; // RULE16
            sh_next = {sh_reg[FRAME_W-2:0], 1'b0};
            cnt_next = cnt_reg - 5'h01;
          end else begin
            data_next = 1'b0;
          end
        end else if (mono_reg > {{(MONO_W-1){1'b0}}, 1'b1}) begin
          mono_next = mono_reg - {{(MONO_W-1){1'b0}}, 1'b1};
        end else begin
          // line keeps the last bit, or goes low on a further edge, until the monoflop runs out
          st_next = EEM_SSI_IDLE; // RULE15
          data_next = 1'b1;
        end
      end
      default: begin
        st_next = EEM_SSI_IDLE;
        data_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= EEM_SSI_IDLE;
      sh_reg <= '0;
      lat_reg <= '0;
      cnt_reg <= 5'h00;
      mono_reg <= '0;
      data_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      lat_reg <= lat_next;
      cnt_reg <= cnt_next;
      mono_reg <= mono_next;
      data_reg <= data_next;
    end
  end

  assign data_out = data_reg;
  assign busy_out = (st_reg == EEM_SSI_ACTIVE);
  assign latched_out = lat_reg;
endmodule : eem_ssi_shift

// *** logic/eem_top.sv ***
// encoder emulation: incremental quadrature and serial absolute output
//
// How it works
// RULE1: position derived from sampled absolute feedback
// RULE2: A and B quarter period apart, plus zero
// RULE3: lines programmable, 4096 resolver, 524288 encoder
// RULE4: one zero pulse per turn, only A=B=1; interpolation mode passes the reference mark through without A=B gating
// RULE5: zero pulse place set by stored offset
// RULE6: default counts up turning clockwise
// RULE7: interpolation gives 2^2..2^7 lines per period
// RULE8: serial frame holds exactly 24 data bits
// RULE9: single-turn: upper 12 zero, position lower 12
// RULE10: single-turn value spans one feedback pole cycle
// RULE11: commutation encoder not homed: upper 12 ones
// RULE12: multi-turn: turns upper 12, position lower 12
// RULE13: frame coded Gray by default, else binary
// RULE14: serial clock rate and polarity selectable
// RULE15: monoflop idle time after last clock edge
// RULE16: first edge latches, then MSB first shifting
// RULE17: minimum spacing between adjacent A/B edges
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module eem_top
  import eem_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic fb_sample_in,
  input wire logic [eem_pkg::ANGLE_W-1:0] fb_angle_in,
  input wire logic fb_ref_mark_in,
  input wire logic ssi_clk_in,
  output logic enc_a_out,
  output logic enc_b_out,
  output logic enc_zero_out,
  output logic ssi_data_out
);
  import eem_pkg::*;

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sh_reg;
  logic rstn;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sh_reg <= 2'b00;
    end else begin
      rst_sh_reg <= {rst_sh_reg[0], 1'b1};
    end
  end
  assign rstn = rst_sh_reg[1];

  logic [1:0] pins_s;
  eem_sync2 #(.WIDTH(2)) u_sync (
    .clk_in(ref_clk_in),
    .rstn_in(rstn),
    .async_in({ssi_clk_in, fb_ref_mark_in}),
    .sync_out(pins_s)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [CTL_W-1:0] ctl_reg, ctl_next;
  logic [LINES_W-1:0] lines_reg, lines_next;
  logic [LINES_W-1:0] zofs_reg, zofs_next;
  logic [2:0] interp_reg, interp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ready_reg, ready_next;
  logic err_reg, err_next;

  eem_fn_t mode;
  logic [1:0] pole_sel;
  assign mode = eem_fn_t'(ctl_reg[CTL_MODE_LSB +: 2]);
  assign pole_sel = ctl_reg[CTL_POLE_LSB +: 2];

  logic signed [ANGLE_W-1:0] out_cnt_reg, out_cnt_next;
  logic [HALF_W-1:0] turns_reg, turns_next;
  logic [FRAME_W-1:0] ssi_latched;
  logic ssi_busy;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == ADDR_CTRL) || (a == ADDR_LINES) || (a == ADDR_ZOFS) ||
      (a == ADDR_INTERP) || (a == ADDR_COUNT) || (a == ADDR_FRAME) ||
      (a == ADDR_TURNS);
  endfunction : mapped

  // zero-wait slave: ready rises in the access phase
  always_comb begin
    ctl_next = ctl_reg;
    lines_next = lines_reg;
    zofs_next = zofs_reg;
    interp_next = interp_reg;
    rdata_next = rdata_reg;
    ready_next = psel_in && !penable_in;
    err_next = psel_in && !penable_in && !mapped(paddr_in);
    if (psel_in && !penable_in) begin
      case (paddr_in)
        ADDR_CTRL: rdata_next = {20'h00000, ctl_reg};
        ADDR_LINES: rdata_next = {12'h000, lines_reg};
        ADDR_ZOFS: rdata_next = {12'h000, zofs_reg};
        ADDR_INTERP: rdata_next = {29'h00000000, interp_reg};
        ADDR_COUNT: rdata_next = {8'h00, out_cnt_reg};
        ADDR_FRAME: rdata_next = {ssi_busy, 7'h00, ssi_latched};
        ADDR_TURNS: rdata_next = {20'h00000, turns_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
    if (psel_in && penable_in && ready_reg && pwrite_in) begin
      case (paddr_in)
        ADDR_CTRL: ctl_next = pwdata_in[CTL_W-1:0];
        ADDR_LINES: lines_next = pwdata_in[LINES_W-1:0]; // RULE3
        ADDR_ZOFS: zofs_next = pwdata_in[LINES_W-1:0]; // RULE5
        ADDR_INTERP: interp_next = pwdata_in[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      ctl_reg <= CTL_RESET;
      lines_reg <= LINES_RESET;
      zofs_reg <= '0;
      interp_reg <= INTERP_MIN;
      rdata_reg <= 32'h00000000;
      ready_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      lines_reg <= lines_next;
      zofs_reg <= zofs_next;
      interp_reg <= interp_next;
      rdata_reg <= rdata_next;
      ready_reg <= ready_next;
      err_reg <= err_next;
    end
  end

  // ----------------------------------------------------------------
  // shaft position tracking
  // ----------------------------------------------------------------
  logic [ANGLE_W-1:0] ang_in;
  logic [ANGLE_W-1:0] ang_reg, ang_next;
  logic [1:0] pcyc_reg, pcyc_next;
  logic [1:0] pp_last;
  logic wrap_up, wrap_dn;
  logic [ANGLE_W-1:0] pos_cur;

  // inverting the angle flips the sense of every output at once
  assign ang_in = ctl_reg[CTL_DIR_INV] ? (~fb_angle_in + 24'h000001)
                                       : fb_angle_in; // RULE6
  // raw angle is stored, so toggling direction makes no position jump
  assign pos_cur = ctl_reg[CTL_DIR_INV] ? (~ang_reg + 24'h000001)
                                        : ang_reg; // RULE6
  assign wrap_up = (pos_cur[ANGLE_W-1 -: 2] == 2'b11) &&
                   (ang_in[ANGLE_W-1 -: 2] == 2'b00);
  assign wrap_dn = (pos_cur[ANGLE_W-1 -: 2] == 2'b00) &&
                   (ang_in[ANGLE_W-1 -: 2] == 2'b11);
  assign pp_last = (pole_sel == 2'b10) ? 2'b10 :
                   (pole_sel == 2'b01) ? 2'b01 : 2'b00;

  always_comb begin
    ang_next = ang_reg;
    pcyc_next = pcyc_reg;
    turns_next = turns_reg;
    if (fb_sample_in) begin
      ang_next = fb_angle_in; // RULE1
      // pole cycles roll into whole motor turns
      if (wrap_up) begin
        if (pcyc_reg >= pp_last) begin
          pcyc_next = 2'b00;
          turns_next = turns_reg + 12'h001;
        end else begin
          pcyc_next = pcyc_reg + 2'b01;
        end
      end else if (wrap_dn) begin
        if (pcyc_reg == 2'b00) begin
          pcyc_next = pp_last;
          turns_next = turns_reg - 12'h001;
        end else begin
          pcyc_next = pcyc_reg - 2'b01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // incremental scaling and edge-limited stepper
  // ----------------------------------------------------------------
  logic [LINES_W-1:0] lines_eff;
  logic [2:0] k_eff;
  logic [LINES_W+1:0] lines4;
  logic signed [ANGLE_W-1:0] delta;
  logic signed [47:0] acc_reg, acc_next;
  logic signed [ANGLE_W-1:0] target;
  logic [LINES_W+1:0] rev_reg, rev_next;
  logic [5:0] gap_reg, gap_next;
  logic [LINES_W-1:0] zofs_eff;
  logic step_en;

  localparam logic [5:0] GAP_RELOAD = 6'(EDGE_SPACING_CYC - 1);

  always_comb begin
    k_eff = interp_reg;
    if (interp_reg < INTERP_MIN) k_eff = INTERP_MIN; // RULE7
    if (interp_reg > INTERP_MAX) k_eff = INTERP_MAX; // RULE7
    if (mode == EEM_FN_INTERP) begin
      lines_eff = LINES_W'(20'h00001 << k_eff); // RULE7
    end else if (!ctl_reg[CTL_ENCODER] && lines_reg > LINES_MAX_RES) begin
      lines_eff = LINES_MAX_RES; // RULE3
    end else if (lines_reg > LINES_MAX_ENC) begin
      lines_eff = LINES_MAX_ENC; // RULE3
    end else if (lines_reg == '0) begin
      lines_eff = 20'h00001;
    end else begin
      lines_eff = lines_reg;
    end
  end

  assign lines4 = {lines_eff, 2'b00};
  assign delta = ang_in - pos_cur;
  assign target = acc_reg[47 -: ANGLE_W];
  assign zofs_eff = (zofs_reg < lines_eff) ? zofs_reg : '0;
  assign step_en = (gap_reg == 6'h00) && (target != out_cnt_reg);

  always_comb begin
    acc_next = acc_reg;
    out_cnt_next = out_cnt_reg;
    rev_next = rev_reg;
    gap_next = gap_reg;
    if (fb_sample_in) begin
      acc_next = acc_reg + 48'(delta * $signed({1'b0, lines4}));
    end
    if (gap_reg != 6'h00) begin
      gap_next = gap_reg - 6'h01;
    end
    if (step_en) begin
      gap_next = GAP_RELOAD; // RULE17
      if (target > out_cnt_reg) begin
        out_cnt_next = out_cnt_reg + 24'sh000001;
        rev_next = (rev_reg + 22'h000001 >= lines4) ? '0
                   : rev_reg + 22'h000001;
      end else begin
        out_cnt_next = out_cnt_reg - 24'sh000001;
        rev_next = (rev_reg == '0) ? lines4 - 22'h000001
                   : rev_reg - 22'h000001;
      end
    end
  end

  // quadrature phase 0:00 1:A 2:AB 3:B, A leads B counting up
  logic [1:0] q_next;
  logic a_next, b_next, z_next;
  assign q_next = out_cnt_next[1:0];

  always_comb begin
    a_next = 1'b0;
    b_next = 1'b0;
    z_next = 1'b0;
    if (mode == EEM_FN_INCR || mode == EEM_FN_INTERP) begin
      a_next = (q_next == 2'b01) || (q_next == 2'b10); // RULE2
      b_next = (q_next == 2'b10) || (q_next == 2'b11); // RULE2
      if (mode == EEM_FN_INTERP) begin
        z_next = pins_s[0];
      end else begin
        // once per turn at the offset line, inside the A=B=1 quarter
        z_next = (rev_next[LINES_W+1:2] == zofs_eff) &&
                 (q_next == 2'b10); // RULE4 RULE5
      end
    end
  end

  // ----------------------------------------------------------------
  // serial absolute output
  // ----------------------------------------------------------------
  logic clk_d_reg;
  logic link_edge;
  logic [HALF_W-1:0] upper;
  logic [FRAME_W-1:0] bin_word;
  logic [FRAME_W-1:0] ssi_word;
  logic [MONO_W-1:0] mono_cyc;
  logic ssi_data;

  // idle-high clock: first active edge is falling unless inverted
  assign link_edge = (mode == EEM_FN_SSI) &&
    (ctl_reg[CTL_CLK_INV] ? (pins_s[1] && !clk_d_reg)
                          : (!pins_s[1] && clk_d_reg)); // RULE14

  always_comb begin
    if (ctl_reg[CTL_ENCODER] && ctl_reg[CTL_COMMUT] &&
        !ctl_reg[CTL_HOMED]) begin
      upper = HALF_INVALID; // RULE11
    end else if (ctl_reg[CTL_MULTI]) begin
      upper = turns_reg; // RULE12
    end else begin
      upper = HALF_ZERO; // RULE9
    end
  end

  // lower half is the pole-cycle angle
  assign bin_word = {upper, pos_cur[ANGLE_W-1 -: HALF_W]}; // RULE9 RULE10
  assign ssi_word = ctl_reg[CTL_BINARY] ? bin_word
                    : (bin_word ^ (bin_word >> 1)); // RULE13
  assign mono_cyc = ctl_reg[CTL_FAST] ? MONO_W'(MONO_FAST_CYC)
                    : MONO_W'(MONO_SLOW_CYC); // RULE14 RULE15

  eem_ssi_shift u_ssi (
    .clk_in(ref_clk_in),
    .rstn_in(rstn),
    .link_edge_in(link_edge),
    .word_in(ssi_word),
    .mono_cyc_in(mono_cyc),
    .data_out(ssi_data),
    .busy_out(ssi_busy),
    .latched_out(ssi_latched)
  );

  // ----------------------------------------------------------------
  // state and output flops
  // ----------------------------------------------------------------
  logic a_reg, b_reg, z_reg, sd_reg;

  always_ff @(posedge ref_clk_in or negedge rstn) begin
    if (!rstn) begin
      ang_reg <= '0;
      pcyc_reg <= 2'b00;
      turns_reg <= '0;
      acc_reg <= '0;
      out_cnt_reg <= '0;
      rev_reg <= '0;
      gap_reg <= 6'h00;
      clk_d_reg <= 1'b0;
      a_reg <= 1'b0;
      b_reg <= 1'b0;
      z_reg <= 1'b0;
      sd_reg <= 1'b1;
    end else begin
      ang_reg <= ang_next;
      pcyc_reg <= pcyc_next;
      turns_reg <= turns_next;
      acc_reg <= acc_next;
      out_cnt_reg <= out_cnt_next;
      rev_reg <= rev_next;
      gap_reg <= gap_next;
      clk_d_reg <= pins_s[1];
      a_reg <= a_next;
      b_reg <= b_next;
      z_reg <= z_next;
      sd_reg <= (mode == EEM_FN_SSI) ? ssi_data : 1'b1;
    end
  end

  assign enc_a_out = a_reg;
  assign enc_b_out = b_reg;
  assign enc_zero_out = z_reg;
  assign ssi_data_out = sd_reg;
  assign prdata_out = rdata_reg;
  assign pready_out = ready_reg;
  assign pslverr_out = err_reg;

  if (EDGE_SPACING_CYC < 1 || EDGE_SPACING_CYC > 64 ||
      MONO_SLOW_CYC >= (1 << MONO_W)) begin : g_bad_timing
    $error("timing counts do not fit their counters");
  end
endmodule : eem_top

// *** tb/eem_properties.sv ***
// port-level timing checker for the encoder emulation block
`timescale 1ns/1ps
module eem_properties
  import eem_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic ssi_clk_in,
  input wire logic enc_a_out,
  input wire logic enc_b_out,
  input wire logic enc_zero_out,
  input wire logic ssi_data_out
);
  localparam int GAP_MIN = EDGE_SPACING_CYC - 1;
  localparam int IDLE_AGE = MONO_SLOW_CYC + 16;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // ------------------------------------------------------------
  // helper counters: cycles since last A/B and serial clock change
  // ------------------------------------------------------------
  logic [1:0] ab_reg;
  logic sclk_reg;
  logic [7:0] gap_reg, gap_next;
  logic [11:0] age_reg, age_next;
  always_comb begin
    gap_next = (ab_reg != {enc_a_out, enc_b_out}) ? 8'h00 :
      gap_reg + {7'h00, gap_reg != 8'hff};
    age_next = (sclk_reg != ssi_clk_in) ? 12'h000 :
      age_reg + {11'h000, age_reg != 12'hfff};
  end
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ab_reg <= 2'b00;
      sclk_reg <= 1'b1;
      gap_reg <= 8'hff;
      age_reg <= 12'h000;
    end else begin
      ab_reg <= {enc_a_out, enc_b_out};
      sclk_reg <= ssi_clk_in;
      gap_reg <= gap_next;
      age_reg <= age_next;
    end
  end
  property p_quad;
    $changed(enc_a_out) |-> !$changed(enc_b_out);
  endproperty
  a_quad: assert property (p_quad) else $error("A and B moved together");
  property p_gap;
    (ab_reg != {enc_a_out, enc_b_out}) |-> gap_reg >= GAP_MIN;
  endproperty
  a_gap: assert property (p_gap) else $error("A/B edges too close");
  property p_zero;
    enc_zero_out |-> enc_a_out && enc_b_out;
  endproperty
  a_zero: assert property (p_zero) else $error("zero pulse outside A=B=1");
  property p_ready;
    psel_in && !penable_in |=> pready_out;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_ready_one;
    pready_out |=> !pready_out;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready too long");
  property p_err;
    pslverr_out |-> pready_out;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_err_data;
    pslverr_out && !pwrite_in |-> prdata_out == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data) else $error("refused read data");
  property p_idle;
    age_reg == IDLE_AGE |-> ssi_data_out;
  endproperty
  a_idle: assert property (p_idle) else $error("data not idle high");
  property p_fall;
    $fell(ssi_data_out) |-> age_reg <= 10;
  endproperty
  a_fall: assert property (p_fall) else $error("data moved w/o edge");
  c_frame: cover property ($fell(ssi_data_out));
  c_err: cover property (pslverr_out);
  c_step: cover property ($changed(enc_a_out));
endmodule : eem_properties

// *** tb/eem_ssi_master.sv ***
// evaluator model: clocks serial position frames out of the block
`timescale 1ns/1ps
module eem_ssi_master (
  output logic ssi_clk_out,
  input wire logic ssi_data_in
);
  logic idle_lvl = 1'b1;
  initial ssi_clk_out = 1'b1;
  // clock stands still at the idle level between frames
  task set_idle(input logic lvl);
    idle_lvl = lvl;
    ssi_clk_out = lvl;
  endtask : set_idle
  // bit read just before the next active edge, long after it settled
  task read_frame(output logic [23:0] w);
    w = 24'h000000;
    for (int i = 0; i < 26; i++) begin
      #24;
      if (i > 1) w = {w[22:0], ssi_data_in};
      if (i < 25) ssi_clk_out = ~idle_lvl;
      #24 ssi_clk_out = idle_lvl;
    end
  endtask : read_frame
endmodule : eem_ssi_master

// *** tb/eem_top_bench.sv ***
// self-checking bench for the encoder emulation block
`timescale 1ns/1ps
module eem_top_bench;
  import eem_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic fb_sample_in = 1'b0;
  logic [ANGLE_W-1:0] fb_angle_in = 24'h000000;
  logic ssi_clk_in, enc_a_out, enc_b_out, enc_zero_out, ssi_data_out;
  logic [31:0] prdata_out, rd;
  logic pready_out, pslverr_out, er;
  logic [23:0] fw;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  always #2.5 ref_clk_in = ~ref_clk_in;
  eem_top eem_top_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .fb_sample_in(fb_sample_in), .fb_angle_in(fb_angle_in),
    .fb_ref_mark_in(1'b0), .ssi_clk_in(ssi_clk_in),
    .enc_a_out(enc_a_out), .enc_b_out(enc_b_out),
    .enc_zero_out(enc_zero_out), .ssi_data_out(ssi_data_out));
  eem_ssi_master eem_ssi_master_i (.ssi_clk_out(ssi_clk_in),
    .ssi_data_in(ssi_data_out));
  // ------------------------------------------------------------
  // report, compare and bus tasks
  // ------------------------------------------------------------
  task stop_test;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      miscompares++;
      stop_test;
    end
  end
  task check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    do @(posedge ref_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task wr_rd(input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] e);
    apb(1'b1, a, d);
    apb(1'b0, a, 32'h0);
    check("register", rd, e);
  endtask : wr_rd
  task sample(input logic [23:0] ang);
    @(posedge ref_clk_in);
    fb_sample_in <= 1'b1;
    fb_angle_in <= ang;
    @(posedge ref_clk_in);
    fb_sample_in <= 1'b0;
  endtask : sample
  task count_is(input logic [23:0] ang, input logic [31:0] e);
    sample(ang);
    repeat (900) @(posedge ref_clk_in);
    apb(1'b0, ADDR_COUNT, 32'h0);
    check("count", rd, e);
  endtask : count_is
  // the wait covers the slow monoflop so every frame starts clean
  task frame(input logic [31:0] ctl, input logic [23:0] e);
    apb(1'b1, ADDR_CTRL, ctl);
    repeat (2 * MONO_SLOW_CYC) @(posedge ref_clk_in);
    eem_ssi_master_i.read_frame(fw);
    check("frame", {8'h00, fw}, {8'h00, e});
    apb(1'b0, ADDR_FRAME, 32'h0);
    check("latched", {8'h00, rd[23:0]}, {8'h00, e});
  endtask : frame
  function automatic logic [23:0] gray(input logic [23:0] b);
    return b ^ (b >> 1);
  endfunction : gray
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (5) @(posedge ref_clk_in);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    apb(1'b0, ADDR_LINES, 32'h0);
    check("lines reset", rd, 32'h400);
    apb(1'b0, ADDR_INTERP, 32'h0);
    check("interp reset", rd, 32'h2);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped", {31'h0, er}, 32'h1);
    wr_rd(ADDR_COUNT, 32'h5, 32'h0);
    wr_rd(ADDR_LINES, 32'h10000, 32'h10000);
    apb(1'b1, ADDR_CTRL, 32'h80);
    wr_rd(ADDR_LINES, 32'hfffff, 32'hfffff);
    wr_rd(ADDR_LINES, 32'h0, 32'h0);
    wr_rd(ADDR_LINES, 32'h400, 32'h400);
    wr_rd(ADDR_ZOFS, 32'h7d0, 32'h7d0);
    wr_rd(ADDR_INTERP, 32'h1, 32'h1);
    wr_rd(ADDR_INTERP, 32'h7, 32'h7);
    apb(1'b1, ADDR_CTRL, 32'h001);
    count_is(24'h004000, 32'h4);
    check("quad", {29'h0, enc_a_out, enc_b_out, enc_zero_out}, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h005);
    count_is(24'h008000, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h001);
    apb(1'b1, ADDR_LINES, 32'h10000);
    count_is(24'h00c000, 32'h10);
    apb(1'b1, ADDR_CTRL, 32'h032);
    sample(24'habc000);
    frame(32'h032, 24'h000abc);
    frame(32'h022, gray(24'h000abc));
    frame(32'h1b2, 24'hfffabc);
    frame(32'h9b2, 24'h000abc);
    frame(32'h012, 24'h000abc);
    repeat (MONO_FAST_CYC + 100) @(posedge ref_clk_in);
    check("monoflop hold", {31'h0, ssi_data_out}, 32'h0);
    repeat (MONO_SLOW_CYC) @(posedge ref_clk_in);
    check("monoflop end", {31'h0, ssi_data_out}, 32'h1);
    eem_ssi_master_i.set_idle(1'b0);
    frame(32'h072, 24'h000abc);
    sample(24'hf00000);
    sample(24'h100000);
    frame(32'h07a, 24'h001100);
    apb(1'b0, ADDR_TURNS, 32'h0);
    check("turns", rd, 32'h1);
    stop_test;
  end
endmodule : eem_top_bench
bind eem_top eem_properties eem_properties_i (.ref_clk_in(ref_clk_in),
  .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .ssi_clk_in(ssi_clk_in), .enc_a_out(enc_a_out), .enc_b_out(enc_b_out),
  .enc_zero_out(enc_zero_out), .ssi_data_out(ssi_data_out));
